// ===== src/rsw_supervisor.sv
// reset supervisor with manual reset input, watchdog and reset output stages
`timescale 1ns/1ps
`default_nettype none
`include "rsw_regs.svh"

module rsw_supervisor #(
  parameter int unsigned HOLD_SEL = `RSW_HOLD_SEL_DEFAULT,
  parameter int unsigned WD_SEL = `RSW_WD_SEL_DEFAULT,
  parameter longint unsigned HOLD_CYCLES = rsw_pkg::rsw_hold_cycles(HOLD_SEL),
  parameter longint unsigned WD_CYCLES = rsw_pkg::rsw_wd_cycles(WD_SEL),
  parameter int unsigned CNT_W = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic manual_reset_request_n,
  input wire logic watchdog_service_input,
  output rsw_pkg::rsw_wdi_drive_t wdi_drive,
  output rsw_pkg::rsw_reset_pins_t reset_pins
);
  import rsw_pkg::*;

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 64'd1);
  localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_CYCLES - 64'd1);
  localparam logic [CNT_W-1:0] SELF_AT =
    CNT_W'((WD_CYCLES * `RSW_SELF_NUM) / `RSW_SELF_DEN - 64'd1);
  localparam int unsigned FLT_W = 16;
  localparam logic [FLT_W-1:0] FLT_LAST =
    FLT_W'(rsw_ns_cycles(`RSW_MR_FILTER_NS) - 64'd1);
  localparam logic [FLT_W-1:0] SELF_LEN = FLT_W'(rsw_ns_cycles(`RSW_SELF_PULSE_NS));

  // input synchronisers and filter state
  logic mr_meta_reg;
  logic mr_meta_next;
  logic mr_sync_reg;
  logic mr_sync_next;
  logic mr_filt_reg;
  logic mr_filt_next;
  logic [FLT_W-1:0] flt_cnt_reg;
  logic [FLT_W-1:0] flt_cnt_next;
  logic wdi_meta_reg;
  logic wdi_meta_next;
  logic wdi_sync_reg;
  logic wdi_sync_next;
  logic wdi_last_reg;
  logic wdi_last_next;
  logic wdi_edge;

  always_comb begin
    mr_meta_next = manual_reset_request_n;
    mr_sync_next = mr_meta_reg;
    wdi_meta_next = watchdog_service_input;
    wdi_sync_next = wdi_meta_reg;
    wdi_last_next = wdi_sync_reg;
  end

  assign wdi_edge = wdi_sync_reg ^ wdi_last_reg;

  // the filter answers bounce and glitch alike: any level must persist
  // for the whole window, so a 100ns dip never reaches the state machine
  always_comb begin
    mr_filt_next = mr_filt_reg;
    flt_cnt_next = '0;
    if (mr_sync_reg != mr_filt_reg) begin
      if (flt_cnt_reg == FLT_LAST) begin
        mr_filt_next = mr_sync_reg;
      end else begin
        flt_cnt_next = flt_cnt_reg + FLT_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // idle levels, so no false edge or press follows reset
      mr_meta_reg <= 1'b1;
      mr_sync_reg <= 1'b1;
      mr_filt_reg <= 1'b1;
      flt_cnt_reg <= '0;
      wdi_meta_reg <= 1'b0;
      wdi_sync_reg <= 1'b0;
      wdi_last_reg <= 1'b0;
    end else begin
      mr_meta_reg <= mr_meta_next;
      mr_sync_reg <= mr_sync_next;
      mr_filt_reg <= mr_filt_next;
      flt_cnt_reg <= flt_cnt_next;
      wdi_meta_reg <= wdi_meta_next;
      wdi_sync_reg <= wdi_sync_next;
      wdi_last_reg <= wdi_last_next;
    end
  end

  // supervisor state and counters
  rsw_state_t state_reg;
  rsw_state_t state_next;
  logic [CNT_W-1:0] hold_cnt_reg;
  logic [CNT_W-1:0] hold_cnt_next;
  logic [CNT_W-1:0] wd_cnt_reg;
  logic [CNT_W-1:0] wd_cnt_next;
  logic [FLT_W-1:0] self_cnt_reg;
  logic [FLT_W-1:0] self_cnt_next;
  rsw_reset_pins_t pins_reg;
  rsw_reset_pins_t pins_next;
  logic reset_on;
  logic wd_expired;
  rsw_wdi_drive_t drive_reg;
  rsw_wdi_drive_t drive_next;

  // an edge in the last count still counts as service
  assign wd_expired = !wdi_edge && (wd_cnt_reg == WD_LAST);

  always_comb begin
    state_next = state_reg;
    hold_cnt_next = '0;
    case (state_reg)
      RSW_RUN: begin
        if (!mr_filt_reg) begin
          state_next = RSW_MANUAL;
        end else if (wd_expired) begin
          state_next = RSW_HOLD;
        end
      end
      RSW_MANUAL: begin
        if (mr_filt_reg) begin
          state_next = RSW_HOLD;
        end
      end
      RSW_HOLD: begin
        if (!mr_filt_reg) begin
          state_next = RSW_MANUAL;
        end else if (hold_cnt_reg == HOLD_LAST) begin
          state_next = RSW_RUN;
        end else begin
          hold_cnt_next = hold_cnt_reg + CNT_W'(1);
        end
      end
      default: begin
        state_next = RSW_HOLD;
      end
    endcase
  end

  // watchdog counter; held clear through reset so it restarts at zero
  always_comb begin
    if (state_reg != RSW_RUN) begin
      wd_cnt_next = '0;
    end else if (wdi_edge) begin
      wd_cnt_next = '0;
    end else if (wd_cnt_reg == WD_LAST) begin
      wd_cnt_next = '0;
    end else begin
      wd_cnt_next = wd_cnt_reg + CNT_W'(1);
    end
  end

  // self-service: a weak low-high-low drive that only shows on the pin
  // when nobody else drives it; a driven pin simply overrides it
  // the count-down fixes the pulse width whatever the pin does meanwhile
  always_comb begin
    self_cnt_next = '0;
    if (state_reg == RSW_RUN && !wdi_edge && wd_cnt_reg == SELF_AT) begin
      self_cnt_next = SELF_LEN;
    end else if (self_cnt_reg != '0) begin
      self_cnt_next = self_cnt_reg - FLT_W'(1);
    end
  end

  // pins follow the next state so every reset view moves on one edge
  assign reset_on = (state_next != RSW_RUN);

  always_comb begin
    // weak drive stays enabled; a stronger processor drive wins on the pin
    drive_next.out = (self_cnt_next != '0);
    drive_next.oe_n = 1'b0;
    pins_next.od_out = 1'b0;
    pins_next.od_oe_n = ~reset_on;
    pins_next.reset_n = ~reset_on;
    pins_next.reset_h = reset_on;
  end

  // power-up enters hold so the processor sees one full reset period
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= RSW_HOLD;
      hold_cnt_reg <= '0;
      wd_cnt_reg <= '0;
      self_cnt_reg <= '0;
      pins_reg.reset_n <= 1'b0;
      pins_reg.reset_h <= 1'b1;
      pins_reg.od_out <= 1'b0;
      pins_reg.od_oe_n <= 1'b0;
      drive_reg.out <= 1'b0;
      drive_reg.oe_n <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      wd_cnt_reg <= wd_cnt_next;
      self_cnt_reg <= self_cnt_next;
      pins_reg <= pins_next;
      drive_reg <= drive_next;
    end
  end

  // both outputs leave flip-flops, so no view glitches between edges
  assign reset_pins = pins_reg;
  assign wdi_drive = drive_reg;

endmodule : rsw_supervisor
`default_nettype wire

// ===== src/rsw_regs.svh
// timing constants and build-time options for the reset supervisor watchdog
`ifndef RSW_REGS_SVH
`define RSW_REGS_SVH

`define RSW_CLK_MHZ 100
// manual input must stay put this long before it is believed
`define RSW_MR_FILTER_NS 1000
// documented glitch width that must be rejected
`define RSW_MR_GLITCH_NS 100
// shortest service pulse that must count as an edge
`define RSW_WDI_MIN_PULSE_NS 50
// width of the self-service high pulse
`define RSW_SELF_PULSE_NS 1000
`define RSW_SELF_NUM 7
`define RSW_SELF_DEN 8

`define RSW_HOLD_0_US 1000
`define RSW_HOLD_1_US 20000
`define RSW_HOLD_2_US 140000
`define RSW_HOLD_3_US 1120000
`define RSW_HOLD_SEL_DEFAULT 2

`define RSW_WD_0_US 6300
`define RSW_WD_1_US 102000
`define RSW_WD_2_US 1600000
`define RSW_WD_3_US 25600000
`define RSW_WD_SEL_DEFAULT 2

`endif

// ===== src/rsw_pkg.sv
// types and cycle-count helpers for the reset supervisor watchdog
`include "rsw_regs.svh"

package rsw_pkg;

  typedef enum logic [1:0] {
    RSW_RUN,
    RSW_MANUAL,
    RSW_HOLD
  } rsw_state_t;

  // the three views of the reset output
  typedef struct packed {
    logic reset_n;
    logic reset_h;
    logic od_out;
    logic od_oe_n;
  } rsw_reset_pins_t;

  // the service pin seen as a two-way pin
  typedef struct packed {
    logic out;
    logic oe_n;
  } rsw_wdi_drive_t;

  function automatic longint unsigned rsw_ns_cycles(input longint unsigned ns);
    rsw_ns_cycles = (ns * `RSW_CLK_MHZ + 64'd999) / 64'd1000;
    if (rsw_ns_cycles == 64'd0) begin
      rsw_ns_cycles = 64'd1;
    end
  endfunction : rsw_ns_cycles

  function automatic longint unsigned rsw_hold_cycles(input int unsigned sel);
    case (sel)
      0: rsw_hold_cycles = 64'(`RSW_HOLD_0_US) * `RSW_CLK_MHZ;
      1: rsw_hold_cycles = 64'(`RSW_HOLD_1_US) * `RSW_CLK_MHZ;
      2: rsw_hold_cycles = 64'(`RSW_HOLD_2_US) * `RSW_CLK_MHZ;
      default: rsw_hold_cycles = 64'(`RSW_HOLD_3_US) * `RSW_CLK_MHZ;
    endcase
  endfunction : rsw_hold_cycles

  function automatic longint unsigned rsw_wd_cycles(input int unsigned sel);
    case (sel)
      0: rsw_wd_cycles = 64'(`RSW_WD_0_US) * `RSW_CLK_MHZ;
      1: rsw_wd_cycles = 64'(`RSW_WD_1_US) * `RSW_CLK_MHZ;
      2: rsw_wd_cycles = 64'(`RSW_WD_2_US) * `RSW_CLK_MHZ;
      default: rsw_wd_cycles = 64'(`RSW_WD_3_US) * `RSW_CLK_MHZ;
    endcase
  endfunction : rsw_wd_cycles

endpackage : rsw_pkg

// ===== verif/rsw_proc_model.sv
// processor model that services the watchdog pin
`timescale 1ns/1ps
`default_nettype none
module rsw_proc_model (
  input wire logic clock,
  input wire logic active,
  input wire logic [15:0] gap,
  output var logic en = 1'b0,
  output var logic val = 1'b0
);
  logic [15:0] cnt_reg = 16'h0;
  always @(posedge clock) begin
    en <= active;
    cnt_reg <= (cnt_reg >= gap) ? 16'h0 : cnt_reg + 16'h1;
    // brief high pulse, low for the rest of each period; gap 0 leaves the pin stuck low
    val <= (gap != 16'h0) && (cnt_reg < 16'h5);
  end
endmodule : rsw_proc_model
`default_nettype wire

// ===== verif/rsw_supervisor_chk.sv
// assertion checker for the reset supervisor watchdog
`timescale 1ns/1ps
`default_nettype none
module rsw_supervisor_chk #(
  parameter longint unsigned HOLD_CYCLES = 200,
  parameter longint unsigned WD_CYCLES = 2000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic manual_reset_request_n,
  input wire logic watchdog_service_input,
  input wire rsw_pkg::rsw_wdi_drive_t wdi_drive,
  input wire rsw_pkg::rsw_reset_pins_t reset_pins
);
  import rsw_pkg::*;
  longint unsigned ml_reg, ml_next, qc_reg, qc_next, lc_reg, lc_next;
  bit wp_reg;
  logic rn;
  assign rn = reset_pins.reset_n;
  // raw counts: manual low run, quiet service pin, reset low run
  always_comb begin
    ml_next = manual_reset_request_n ? 64'd0 : ml_reg + 64'd1;
    qc_next = (!rn || watchdog_service_input != wp_reg) ? 64'd0 : qc_reg + 64'd1;
    lc_next = rn ? 64'd0 : lc_reg + 64'd1;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ml_reg <= 64'd0;
      qc_reg <= 64'd0;
      lc_reg <= 64'd0;
    end else begin
      ml_reg <= ml_next;
      qc_reg <= qc_next;
      lc_reg <= lc_next;
    end
    wp_reg <= watchdog_service_input;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_inv; reset_pins.reset_h == !rn; endproperty
  property p_od; reset_pins.od_oe_n == rn && !reset_pins.od_out; endproperty
  property p_mr; ml_reg >= 112 |-> !rn; endproperty
  property p_fall; $fell(rn) |-> ml_reg >= 95 || qc_reg + 8 >= WD_CYCLES; endproperty
  property p_hold; $rose(rn) |-> lc_reg + 1 >= HOLD_CYCLES; endproperty
  property p_rel; $rose(rn) |-> rn[*8]; endproperty
  property p_wd; qc_reg <= WD_CYCLES + 8; endproperty
  property p_self; $rose(wdi_drive.out) |-> rn && !wdi_drive.oe_n ##0 wdi_drive.out[*8]; endproperty
  a_inv: assert property (p_inv) else $error("high output not inverse");
  a_od: assert property (p_od) else $error("open drain stage wrong");
  a_mr: assert property (p_mr) else $error("manual low without reset");
  a_fall: assert property (p_fall) else $error("reset without cause");
  a_hold: assert property (p_hold) else $error("hold too short");
  a_rel: assert property (p_rel) else $error("reset after release");
  a_wd: assert property (p_wd) else $error("watchdog late");
  a_self: assert property (p_self) else $error("self pulse wrong");
  c_man: cover property ($fell(rn) && ml_reg >= 95);
  c_wd: cover property ($fell(rn) && qc_reg + 8 >= WD_CYCLES);
  c_self: cover property ($rose(wdi_drive.out));
endmodule : rsw_supervisor_chk
bind rsw_supervisor rsw_supervisor_chk #(.HOLD_CYCLES(HOLD_CYCLES), .WD_CYCLES(WD_CYCLES)) u_chk (
  .clock(clock), .rst_n(rst_n), .manual_reset_request_n(manual_reset_request_n),
  .watchdog_service_input(watchdog_service_input), .wdi_drive(wdi_drive), .reset_pins(reset_pins));
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the reset supervisor watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %0h got %0h", n, e, v); end end
module tb_top;
  import rsw_pkg::*;
  localparam longint unsigned HOLD = 200;
  localparam longint unsigned WD = 2000;
  logic clock = 1'b0, rst_n = 1'b0, mr_n = 1'b1, act = 1'b1, en, val, pin;
  logic [15:0] gap = 16'h0;
  rsw_wdi_drive_t wd;
  rsw_reset_pins_t pins;
  int mismatches = 0, cmp_count = 0, rel = 0;
  longint unsigned lc = 0, e, expq[$];
  initial forever #5 clock = ~clock;
  // the weak self drive loses whenever the processor drives
  assign pin = en ? val : wd.out;
  rsw_supervisor #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WD)) i_dut (.clock(clock), .rst_n(rst_n),
    .manual_reset_request_n(mr_n), .watchdog_service_input(pin), .wdi_drive(wd), .reset_pins(pins));
  rsw_proc_model i_proc (.clock(clock), .active(act), .gap(gap), .en(en), .val(val));
  always @(negedge clock) begin
    if (!rst_n) lc = 0;
    else if (pins.reset_n !== 1'b1) lc++;
    else if (lc != 0) begin
      rel++;
      if (expq.size() == 0) `CHK("spurious reset", 0, lc)
      else begin e = expq.pop_front(); `CHK("low span", 1'b1, lc + 4 >= e && lc <= e + 8) end
      lc = 0;
    end
  end
  task step(int n); repeat (n) @(posedge clock); endtask : step
  task wait_rel(longint unsigned n);
    int r0;
    r0 = rel;
    for (int i = 0; i < n && rel == r0; i++) @(posedge clock);
    `CHK("release", 1'b1, rel != r0)
  endtask : wait_rel
  task report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h3B0E2ACD));
    step(10);
    rst_n <= 1'b1;
    gap <= 16'(800 + $urandom % 600);
    expq.push_back(HOLD);
    wait_rel(HOLD + 50);
    // five cycle pulses keep it alive
    step(6000);
    $display("test service done");
    repeat (8) begin mr_n <= 1'b0; step(1 + $urandom % 60); mr_n <= 1'b1; step(200); end
    repeat (5) begin mr_n <= 1'b0; step(20); mr_n <= 1'b1; step(10); end
    mr_n <= 1'b0;
    step(300);
    mr_n <= 1'b1;
    expq.push_back(HOLD + 300);
    wait_rel(HOLD + 400);
    $display("test manual done");
    gap <= 16'h0;
    expq.push_back(HOLD);
    wait_rel(WD + HOLD + 100);
    gap <= 16'(800 + $urandom % 600);
    $display("test timeout done");
    act <= 1'b0;
    step(3 * WD);
    act <= 1'b1;
    $display("test float done");
    rst_n <= 1'b0;
    step(3);
    rst_n <= 1'b1;
    expq.push_back(HOLD);
    wait_rel(HOLD + 50);
    `CHK("pending", 0, expq.size())
    $display("test rerun done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
